// >>> verif/spcsp_front_checker.sv
// Purpose: port assertions for the command front end
// Assumes: select reaches the core through two flops
// Notes:   windows are short as the bench firmware answers fast
`timescale 1ns/1ps
module spcsp_front_checker (
  input wire        CLK,        // clock
  input wire        ARST_N,     // reset
  input wire        SS_N,       // select
  input wire        MISO_OE,    // miso drive
  input wire        RB_OE,      // busy pull
  input wire        INT_OE,     // irq pull
  input wire        CMD_VALID,  // cmd out
  input wire [15:0] CMD_WORD,   // cmd word
  input wire        CONV_RUN,   // converting
  input wire        CONV_START, // convert
  input wire        THR_EN,     // thr enable
  input wire        WORD_EN,    // word enable
  input wire [15:0] WORD_PTR    // pointer
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // drive only while selected, commands only from a live frame
  chk_miso_float: assert property (SS_N [*4] |-> !MISO_OE) else $error("miso driven");
  chk_cmd_sel: assert property (CMD_VALID |-> $past(MISO_OE)) else $error("cmd no frame");
  chk_cmd_pulse: assert property (CMD_VALID |=> !CMD_VALID) else $error("cmd long");
  chk_cmd_class: assert property (CMD_VALID |-> CMD_WORD[15:14] != 2'h0)
    else $error("class 0 handed on");
  chk_busy_class3: assert property (CMD_VALID && CMD_WORD[15:14] == 2'h3 |-> ##[0:2] RB_OE)
    else $error("no busy");
  // interrupt set by an enabled event, dropped only inside a frame
  chk_int_cause: assert property ($rose(INT_OE) |-> $past(THR_EN) || $past(WORD_EN))
    else $error("irq unenabled");
  chk_int_clear: assert property ($fell(INT_OE) |-> $past(MISO_OE)) else $error("irq dropped");
  chk_wptr_zero: assert property (CONV_START && !CONV_RUN |-> ##[1:3] WORD_PTR == 16'h0000)
    else $error("pointer kept");
  cover property (CMD_VALID && CMD_WORD[15:14] == 2'h3);
  cover property ($rose(INT_OE));
  cover property ($fell(INT_OE));
endmodule // spcsp_front_checker
bind spcsp_front spcsp_front_checker spcsp_front_checker_i (.CLK(CLK), .ARST_N(ARST_N),
  .SS_N(SS_N), .MISO_OE(MISO_OE), .RB_OE(RB_OE), .INT_OE(INT_OE), .CMD_VALID(CMD_VALID),
  .CMD_WORD(CMD_WORD), .CONV_RUN(CONV_RUN), .CONV_START(CONV_START), .THR_EN(THR_EN),
  .WORD_EN(WORD_EN), .WORD_PTR(WORD_PTR));

// >>> verif/spcsp_host.sv
// Purpose: spi master model for the command front end
// Assumes: mode 0, msb first, link period of eight clocks
// Notes:   link clock idles low; mosi inverts when released
`timescale 1ns/1ps
module spcsp_host (
  input  wire  CLK,     // bench clock
  input  wire  MISO_IN, // resolved miso
  output logic SCLK,    // link clock
  output logic SS_N,    // select
  output logic MOSI     // data out
);
  logic [7:0] tx [0:15];
  logic [7:0] rx [0:15];
  initial begin
    SCLK = 1'b0;
    SS_N = 1'b1;
    MOSI = 1'b0;
  end
  // guard time either side lets the synchronisers settle
  task sel(input logic on);
    repeat (4) @(posedge CLK);
    SS_N <= !on;
    if (!on) MOSI <= !MOSI;
    repeat (8) @(posedge CLK);
  endtask
  // whole bytes only; data set while low, taken at the rise
  task shift(input integer f, input integer n);
    integer i, b;
    for (i = f; i < f + n; i++) begin
      for (b = 7; b >= 0; b--) begin
        MOSI <= tx[i][b];
        repeat (4) @(posedge CLK);
        SCLK <= 1'b1;
        repeat (4) @(posedge CLK);
        rx[i][b] = MISO_IN;
        SCLK <= 1'b0;
      end
    end
  endtask
endmodule // spcsp_host

// >>> verif/tb_spi_command_status_protocol.sv
// Purpose: self-checking bench for the command front end
// Assumes: short power-up parameter, firmware side driven here
// Notes:   seeded random levels with fixed corner cases
`timescale 1ns/1ps
module tb_spi_command_status_protocol;
  logic CLK = 0, ARST_N = 0, DATA_TAKE = 0, RES_VALID = 0, CONV_RUN = 0, CONV_START = 0;
  logic CONV_DONE = 0, WORD_DONE = 0, ABBR_DONE = 0, AUDIO_ON = 0, CMD_BUSY = 0, THR_EN = 0;
  logic WORD_EN = 0;
  logic [15:0] RES_PAIR = 16'h0000, cw = 16'h0000;
  logic [8:0] TEXT_LEVEL = 9'h000, TEXT_THR = 9'h1FF;
  logic [31:0] r;
  wire SCLK, SS_N, MOSI, MISO, MISO_OE, RB_OE, INT_OE, CMD_VALID, DATA_VALID;
  wire [15:0] CMD_WORD, WORD_PTR;
  wire [7:0] DATA_BYTE;
  wire miso_w = MISO_OE ? MISO : 1'b1; // tri-state with pull-up
  integer n_errors = 0, samples_checked = 0, i, seed = 32'h175e;
  spcsp_front #(.PWUP_CYC(2)) spcsp_front_i (.CLK(CLK), .ARST_N(ARST_N), .SCLK(SCLK),
    .SS_N(SS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE), .RB_OE(RB_OE), .INT_OE(INT_OE),
    .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD), .DATA_VALID(DATA_VALID), .DATA_BYTE(DATA_BYTE),
    .DATA_TAKE(DATA_TAKE), .RES_VALID(RES_VALID), .RES_PAIR(RES_PAIR), .CONV_RUN(CONV_RUN),
    .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .WORD_DONE(WORD_DONE),
    .ABBR_DONE(ABBR_DONE), .AUDIO_ON(AUDIO_ON), .CMD_BUSY(CMD_BUSY), .TEXT_LEVEL(TEXT_LEVEL),
    .TEXT_THR(TEXT_THR), .THR_EN(THR_EN), .WORD_EN(WORD_EN), .WORD_PTR(WORD_PTR));
  spcsp_host spcsp_host_i (.CLK(CLK), .MISO_IN(miso_w), .SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI));
  initial forever #20 CLK = ~CLK;
  // keep the last word handed to firmware
  always @(posedge CLK) if (CMD_VALID) cw <= CMD_WORD;
  function automatic [15:0] exp_st(input logic rdy, ign, wrd);
    exp_st = {1'b1, 4'h0, 1'b0, 1'b0, ign, wrd, 2'b00, AUDIO_ON, 1'b0,
              TEXT_LEVEL == 9'h000, CONV_RUN, rdy};
  endfunction
  task check16(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmd(input logic [7:0] op, input logic fin);
    r = $random(seed);
    spcsp_host_i.tx[0] = op;
    spcsp_host_i.tx[1] = r[7:0];
    spcsp_host_i.sel(1'b1);
    spcsp_host_i.shift(0, 2);
    if (fin) spcsp_host_i.sel(1'b0);
  endtask
  task peek(input logic rdy, ign, wrd);
    cmd(8'h04, 1'b1);
    check16("status", exp_st(rdy, ign, wrd), {spcsp_host_i.rx[0], spcsp_host_i.rx[1]});
  endtask
  task peek_or(input logic [15:0] ext);
    cmd(8'h04, 1'b1);
    check16("status", exp_st(1, 0, 0) | ext, {spcsp_host_i.rx[0], spcsp_host_i.rx[1]});
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge CLK);
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    peek(0, 0, 0);
    cmd(8'h49, 1'b1);
    peek(0, 1, 0);
    cmd(8'h02, 1'b1);
    peek(1, 0, 0);
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      {AUDIO_ON, CONV_RUN} <= r[1:0];
      TEXT_LEVEL <= (i == 0) ? 9'h000 : {1'b0, r[15:8]};
      @(posedge CLK);
      peek(1, 0, 0);
    end
    CONV_RUN <= 1'b0;
    WORD_DONE <= 1'b1;
    @(posedge CLK);
    WORD_DONE <= 1'b0;
    repeat (2) @(posedge CLK);
    check16("wptr", 16'h0001, WORD_PTR);
    check16("int", 16'h0000, {15'h0, INT_OE});
    WORD_EN <= 1'b1;
    WORD_DONE <= 1'b1;
    CONV_START <= 1'b1;
    @(posedge CLK);
    {WORD_DONE, CONV_START} <= 2'b00;
    repeat (4) @(posedge CLK);
    check16("int", 16'h0001, {15'h0, INT_OE});
    check16("wptr", 16'h0000, WORD_PTR);
    cmd(8'h06, 1'b1);
    check16("status", exp_st(1, 0, 1), {spcsp_host_i.rx[0], spcsp_host_i.rx[1]});
    check16("int", 16'h0000, {15'h0, INT_OE});
    peek(1, 0, 0);
    cmd(8'hC0, 1'b0);
    repeat (8) @(posedge CLK);
    check16("busy", 16'h0001, {15'h0, RB_OE});
    check16("cmd", {8'hC0, spcsp_host_i.tx[1]}, cw);
    r = $random(seed);
    RES_PAIR <= r[15:0];
    RES_VALID <= 1'b1;
    @(posedge CLK);
    RES_VALID <= 1'b0;
    for (i = 0; i < 50 && RB_OE; i++) @(posedge CLK);
    spcsp_host_i.shift(2, 2);
    check16("result", r[15:0], {spcsp_host_i.rx[2], spcsp_host_i.rx[3]});
    repeat (8) @(posedge CLK);
    check16("busy", 16'h0001, {15'h0, RB_OE});
    spcsp_host_i.sel(1'b0);
    cmd(8'h81, 1'b0);
    for (i = 2; i < 10; i++) spcsp_host_i.tx[i] = $random(seed);
    spcsp_host_i.shift(2, 8);
    check16("repeat", exp_st(1, 0, 0), {spcsp_host_i.rx[2], spcsp_host_i.rx[3]});
    check16("repeat", exp_st(1, 0, 0), {spcsp_host_i.rx[8], spcsp_host_i.rx[9]});
    repeat (8) @(posedge CLK);
    check16("busy", 16'h0001, {15'h0, RB_OE});
    spcsp_host_i.sel(1'b0);
    for (i = 2; i < 10; i++) begin
      check16("data", {8'h00, spcsp_host_i.tx[i]}, {8'h00, DATA_BYTE});
      DATA_TAKE <= 1'b1;
      @(posedge CLK);
      DATA_TAKE <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    check16("busy", 16'h0000, {15'h0, RB_OE});
    check16("dvalid", 16'h0000, {15'h0, DATA_VALID});
    // full flag: set at all ones, kept at 127 free, dropped at 128 free
    TEXT_LEVEL <= 9'h1FF;
    @(posedge CLK);
    TEXT_LEVEL <= 9'h180;
    repeat (2) @(posedge CLK);
    peek_or(16'h0008);
    TEXT_LEVEL <= 9'h17F;
    repeat (2) @(posedge CLK);
    peek_or(16'h0000);
    // sticky events: conversion done, abbreviation done, fill falling below threshold
    THR_EN <= 1'b1;
    TEXT_THR <= 9'h080;
    TEXT_LEVEL <= 9'h0C0;
    CONV_DONE <= 1'b1;
    ABBR_DONE <= 1'b1;
    @(posedge CLK);
    {CONV_DONE, ABBR_DONE} <= 2'b00;
    TEXT_LEVEL <= 9'h040;
    repeat (3) @(posedge CLK);
    check16("int", 16'h0001, {15'h0, INT_OE});
    cmd(8'h06, 1'b1);
    check16("events", exp_st(1, 0, 0) | 16'h0460, {spcsp_host_i.rx[0], spcsp_host_i.rx[1]});
    check16("int", 16'h0000, {15'h0, INT_OE});
    peek_or(16'h0000);
    // class 1 word reaches firmware, extra bytes are dropped
    cmd(8'h4E, 1'b0);
    spcsp_host_i.shift(2, 2);
    spcsp_host_i.sel(1'b0);
    check16("cmd", {8'h4E, spcsp_host_i.tx[1]}, cw);
    check16("dvalid", 16'h0000, {15'h0, DATA_VALID});
    print_verdict;
  end
endmodule // tb_spi_command_status_protocol

// >>> verilog/spcsp_defines.vh
// Purpose: constants for the serial command and status front end
// Assumes: included by the front end module only
// Notes:   status bit positions are within the 16-bit status word
`ifndef SPCSP_DEFINES_VH
`define SPCSP_DEFINES_VH
// command classes from the top two bits of the command byte
`define SPCSP_CLASS0        2'h0
`define SPCSP_CLASS1        2'h1
`define SPCSP_CLASS2        2'h2
`define SPCSP_CLASS3        2'h3
// class 0 opcodes handled in hardware
`define SPCSP_OP_PEEK       8'h04
`define SPCSP_OP_RCLR       8'h06
`define SPCSP_OP_PWUP       8'h02
// status word bit positions (byte 1 in the upper half)
`define SPCSP_B_RDY         0
`define SPCSP_B_CONV_RUN    1
`define SPCSP_B_TXT_EMPTY   2
`define SPCSP_B_TXT_FULL    3
`define SPCSP_B_AUDIO_ON    4
`define SPCSP_B_CONV_DONE   5
`define SPCSP_B_THR_EVT     6
`define SPCSP_B_WORD_EVT    7
`define SPCSP_B_IGNORED     8
`define SPCSP_B_ABBR_DONE   10
`define SPCSP_B_RB          15
// power-up latency
`define SPCSP_PWUP_NS       1000
`define SPCSP_CLK_NS        40
`define SPCSP_PWUP_CYC      ((`SPCSP_PWUP_NS + `SPCSP_CLK_NS - 1) / `SPCSP_CLK_NS)
// text buffer release space and data fifo depth
`define SPCSP_TEXT_BUFFER_FULL_FLAG_FREE     128
`define SPCSP_FIFO_DEPTH    8
`endif

// >>> verilog/spcsp_front.v
// Purpose: spi slave command front end: status shift, class decode, flow control
// Assumes: SCLK mode 0, msb first; SCLK, SS_N, MOSI asynchronous to CLK
// Notes:   firmware side is modelled by plain ports (events, text level, results)
`timescale 1ns/1ps
`include "spcsp_defines.vh"
module spcsp_front #(
  parameter PWUP_CYC = `SPCSP_PWUP_CYC,  // power-up latency in clocks
  parameter DEPTH    = `SPCSP_FIFO_DEPTH, // data fifo depth
  parameter TBW      = 9                  // text buffer level width
) (
  input  wire       CLK,          // system clock, 25 MHz
  input  wire       ARST_N,       // asynchronous reset, active low
  input  wire       SCLK,         // spi clock from host
  input  wire       SS_N,         // slave select, active low
  input  wire       MOSI,         // serial data in
  output reg        MISO,         // serial data out
  output wire       MISO_OE,      // miso driven while selected
  output wire       RB_OE,        // ready/busy open drain pull-down enable
  output wire       INT_OE,       // interrupt open drain pull-down enable
  output reg        CMD_VALID,    // pulse: class 1/3 command word to firmware
  output reg [15:0] CMD_WORD,     // command byte and data byte
  output reg        DATA_VALID,   // level: fifo byte available to firmware
  output reg  [7:0] DATA_BYTE,    // fifo head byte
  input  wire       DATA_TAKE,    // firmware pops a fifo byte
  input  wire       RES_VALID,    // pulse: result pair ready
  input  wire [15:0] RES_PAIR,    // word_pointer_high/low result pair
  input  wire       CONV_RUN,     // conversion running level
  input  wire       CONV_START,   // pulse: convert command starts
  input  wire       CONV_DONE,    // pulse: conversion finished
  input  wire       WORD_DONE,    // pulse: a word has been spoken
  input  wire       ABBR_DONE,    // pulse: abbreviation add/delete done
  input  wire       AUDIO_ON,     // digital audio port enabled level
  input  wire       CMD_BUSY,     // firmware still on previous command
  input  wire [TBW-1:0] TEXT_LEVEL, // text buffer fill in bytes
  input  wire [TBW-1:0] TEXT_THR,   // threshold from signalling config
  input  wire       THR_EN,       // threshold event enabled
  input  wire       WORD_EN,      // word event enabled
  output reg [15:0] WORD_PTR      // word pointer count
);
  localparam S_CMD  = 2'h0;  // command word in, status word out
  localparam S_DATA = 2'h1;  // class 2 bytes go into the fifo
  localparam S_WAIT = 2'h2;  // class 3 result pairs go out
  localparam S_DROP = 2'h3;  // rest of the frame is discarded
  localparam PW     = 12;    // power-up counter width

  // synchronisers: first stage read only by second stage
  reg [1:0] sclk_s;  // link clock synchroniser
  reg [1:0] ss_s;    // select synchroniser
  reg [1:0] mosi_s;  // serial data synchroniser
  reg       sclk_d;  // delayed link clock for edge finding
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_s <= 2'h0;
      ss_s   <= 2'h3;
      mosi_s <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], SCLK};
      ss_s   <= {ss_s[0], SS_N};
      mosi_s <= {mosi_s[0], MOSI};
      sclk_d <= sclk_s[1];
    end
  end
  // edges count only inside a frame, so a stray clock while deselected is harmless
  wire sel  = ~ss_s[1];
  wire rise = sel & sclk_s[1] & ~sclk_d;
  wire fall = sel & ~sclk_s[1] & sclk_d;

  // sequencer, shifters and flag state
  reg  [1:0]    state;      // transaction sequencer
  reg  [2:0]    bitc;       // bit within the byte
  reg  [7:0]    shin;       // incoming byte
  reg  [15:0]   shout;      // outgoing status or result
  reg           second;     // second byte of a pair
  reg  [7:0]    cmd_byte;   // first byte of the command word
  reg           powered;    // power-up command seen
  reg  [PW-1:0] pw_cnt;     // power-up latency countdown
  reg           rdy;        // powered-ready flag
  reg           busy3;      // class 3 result pending
  reg  [15:0]   res;        // result pair, high byte first
  reg           txt_full;   // text buffer full, sticky
  reg           conv_flag;  // conversion finished event
  reg           thr_flag;   // fill fell back below threshold
  reg           word_flag;  // word spoken event
  reg           abbr_flag;  // abbreviation add or delete done
  reg           ign_flag;   // last command word was ignored
  reg           above;      // fill has been above threshold
  reg           intr;       // interrupt pending
  reg  [7:0]    fifo [0:DEPTH-1]; // data bytes towards firmware
  reg  [3:0]    wp;         // fifo write pointer, one extra wrap bit
  reg  [3:0]    rp;         // fifo read pointer, one extra wrap bit
  // extra pointer bit tells full from empty without a separate counter
  wire [3:0]  cnt  = wp - rp;
  wire        full = (cnt == DEPTH);
  wire        rb   = ~full & ~busy3;
  wire        byte_done = rise & (bitc == 3'h7);
  wire [7:0]  nb = {shin[6:0], mosi_s[1]};
  wire [1:0]  cls = cmd_byte[7:6];

  // status word, reserved bits tied to zero
  wire [15:0] status = {rb, 4'h0, abbr_flag, 1'b0, ign_flag,
                        word_flag, thr_flag, conv_flag, AUDIO_ON, txt_full,
                        (TEXT_LEVEL == {TBW{1'b0}}), CONV_RUN, rdy};

  assign MISO_OE = sel;
  assign RB_OE   = ~rb;
  assign INT_OE  = intr;

  // serial shifter and transaction sequencer
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= S_CMD;
      bitc      <= 3'h0;
      shin      <= 8'h00;
      shout     <= 16'h0000;
      second    <= 1'b0;
      cmd_byte  <= 8'h00;
      MISO      <= 1'b0;
      wp        <= 4'h0;
      CMD_VALID <= 1'b0;
      CMD_WORD  <= 16'h0000;
      busy3     <= 1'b0;
      res       <= 16'h0000;
    end else begin
      CMD_VALID <= 1'b0;
      if (RES_VALID && busy3) begin
        busy3 <= 1'b0;
        res   <= RES_PAIR;
      end
      if (!sel) begin
        // select high ends everything, even mid byte; a pending result is
        // abandoned so that busy cannot outlive the frame that asked for it
        state  <= S_CMD;
        bitc   <= 3'h0;
        second <= 1'b0;
        busy3  <= 1'b0;
        shout <= status;
        MISO  <= status[15];
      end else begin
        if (fall) begin
          MISO  <= shout[15];
        end
        if (rise) begin
          shin  <= nb;
          bitc  <= bitc + 3'h1;
          shout <= {shout[14:0], 1'b0};
        end
        if (byte_done) begin
          second <= ~second;
          case (state)
            S_CMD: begin
              if (!second) begin
                cmd_byte <= nb;
              end else if (ignore_now(cls, powered, CMD_BUSY)) begin
                state <= S_DROP;
              end else if (cls == `SPCSP_CLASS0) begin
                state <= S_DROP;
              end else begin
                CMD_VALID <= (cls != `SPCSP_CLASS2);
                CMD_WORD  <= {cmd_byte, nb};
                if (cls == `SPCSP_CLASS1) state <= S_DROP;
                else if (cls == `SPCSP_CLASS2) state <= S_DATA;
                else begin
                  state <= S_WAIT;
                  busy3 <= 1'b1;
                end
              end
              if (second && cls == `SPCSP_CLASS3 && !ignore_now(cls, powered, CMD_BUSY))
                shout <= 16'h0000;
              else if (second)
                shout <= status;
            end
            S_DATA: begin
              if (rb) begin
                fifo[wp[2:0]] <= nb;
                wp <= wp + 4'h1;
              end
              if (second) shout <= status;
            end
            S_WAIT: begin
              if (second) begin
                busy3 <= 1'b1;
                shout <= 16'h0000;
              end else begin
                shout <= {res[7:0], 8'h00};
              end
            end
            default: state <= S_DROP;
          endcase
        end
        // busy3 cleared means result is loaded for the coming pair
        // the first result bit must already stand on the pin before the first
        // rise, since the last fall of the command word drove a zero
        if (state == S_WAIT && !busy3 && bitc == 3'h0 && !second && !rise) begin
          shout <= {res[15:8], res[7:0]};
          MISO  <= res[15];
        end
      end
    end
  end

  // non class 0 ignored when firmware busy or while powered down
  function ignore_now(input [1:0] c, input p, input b);
    begin
      ignore_now = (c != `SPCSP_CLASS0) && (!p || b);
    end
  endfunction

  // fifo read side to firmware
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rp         <= 4'h0;
      DATA_VALID <= 1'b0;
      DATA_BYTE  <= 8'h00;
    end else begin
      // head byte is looked ahead so that a pop shows the next byte at once
      if (DATA_TAKE && cnt != 4'h0) rp <= rp + 4'h1;
      DATA_VALID <= (cnt != 4'h0) && !(DATA_TAKE && cnt == 4'h1);
      DATA_BYTE  <= (DATA_TAKE && cnt != 4'h0) ? fifo[rp[2:0] + 3'h1] : fifo[rp[2:0]];
    end
  end

  // class 0 hardware commands, power-up latency and sticky flags
  wire cmd_end = byte_done && state == S_CMD && second;
  wire rclr    = cmd_end && cmd_byte == `SPCSP_OP_RCLR;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      powered   <= 1'b0;
      pw_cnt    <= {PW{1'b0}};
      rdy       <= 1'b0;
      txt_full  <= 1'b0;
      conv_flag <= 1'b0;
      thr_flag  <= 1'b0;
      word_flag <= 1'b0;
      abbr_flag <= 1'b0;
      ign_flag  <= 1'b0;
      above     <= 1'b0;
      intr      <= 1'b0;
      WORD_PTR  <= 16'h0000;
    end else begin
      // power-up latency: ready rises a fixed count after the power-up word
      if (cmd_end && cmd_byte == `SPCSP_OP_PWUP && !powered) begin
        powered <= 1'b1;
        pw_cnt  <= PWUP_CYC[PW-1:0];
      end else if (powered && !rdy) begin
        if (pw_cnt <= {{(PW-1){1'b0}}, 1'b1}) rdy <= 1'b1;
        else pw_cnt <= pw_cnt - {{(PW-1){1'b0}}, 1'b1};
      end
      // ignored flag is refreshed by every command word, class 0 included
      if (cmd_end) ign_flag <= ignore_now(cls, powered, CMD_BUSY);
      // full holds until 128 bytes are free again, so the host sees no flicker
      if (TEXT_LEVEL == {TBW{1'b1}}) txt_full <= 1'b1;
      else if ({1'b0, ~TEXT_LEVEL} >= `SPCSP_TEXT_BUFFER_FULL_FLAG_FREE) txt_full <= 1'b0;
      // a new conversion restarts the pointer, a spoken word advances it
      if (CONV_START && !CONV_RUN) WORD_PTR <= 16'h0000;
      else if (WORD_DONE) WORD_PTR <= WORD_PTR + 16'h0001;
      // threshold tracking: equal level keeps the last side
      if (TEXT_LEVEL > TEXT_THR) above <= 1'b1;
      else if (TEXT_LEVEL < TEXT_THR) above <= 1'b0;
      // set wins over the read-and-clear, so no event is lost in that cycle
      conv_flag <= CONV_DONE | (conv_flag & ~rclr);
      thr_flag  <= (above & (TEXT_LEVEL < TEXT_THR)) | (thr_flag & ~rclr);
      word_flag <= (WORD_DONE & WORD_EN) | (word_flag & ~rclr);
      abbr_flag <= ABBR_DONE | (abbr_flag & ~rclr);
      // interrupt pin follows only the enabled events
      intr <= (above & (TEXT_LEVEL < TEXT_THR) & THR_EN) |
              (WORD_DONE & WORD_EN) | (intr & ~rclr);
    end
  end
endmodule // spcsp_front
